// >>> dv/core_model.sv
// behavioural core that takes a pending interrupt promptly or after a delay
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic take_en,
  input wire logic slow,
  input wire logic core_interrupt_request,
  output var logic core_interrupt_accept
);
  logic [2:0] wait_count;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_count <= 3'h0;
      core_interrupt_accept <= 1'h0;
    end else if (take_en && core_interrupt_request && !core_interrupt_accept) begin
      // only a live request is answered; a slow core lets it stand four cycles longer than a prompt one
      core_interrupt_accept <= (wait_count >= (slow ? 3'h4 : 3'h0));
      wait_count <= wait_count + 3'h1;
    end else begin
      core_interrupt_accept <= 1'h0;
      wait_count <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// >>> dv/primary_interrupt_control_bench.sv
// self-checking bench for the primary interrupt control
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module primary_interrupt_control_bench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, take_en = 0, slow = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [5:0] src = 0;
  logic [7:0] lf = 8'h59, e;
  logic hreadyout, hresp, req, acc, irq;
  int bad_count = 0, checks_done = 0;
  primary_interrupt_control u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .ext_interrupt_pin(src[5]), .low_voltage_detector_out(src[4]),
    .comparator_one_event(src[3]), .timer_one_event(src[2]),
    .comparator_two_event(src[1]), .comparator_three_event(src[0]),
    .core_interrupt_accept(acc), .core_interrupt_request(req), .irq);
  core_model u_core (.hclk, .hresetn, .take_en, .slow, .core_interrupt_request(req),
    .core_interrupt_accept(acc));
  initial forever #5 hclk = ~hclk;
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [7:0] prim_exp(input int i, input int s);
    if (i == 5 - s) return 8'h40;
    if (i == 3) return 8'h20;
    if (i < 3) return 8'h10;
    return 8'h00;
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'h1 && n < 50);
    if (n >= 50) begin bad_count++; wrap_up; end
  endtask
  // entered right after a rising edge; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task automatic fire(input int i);
    src[i] <= 1;
    @(posedge hclk);
    src[i] <= 0;
    repeat (4) @(posedge hclk);
  endtask
  initial begin
    int n;
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    for (int a = 0; a < 24; a += 4) begin
      bus(0, a[7:0], 0);
      `CHK("reset value", 32'h0, q)
    end
    $display("reset values done");
    for (int k = 0; k < 8; k++) begin
      lf = nxt(lf);
      bus(1, 8'h00, {24'h0, lf});
      bus(0, 8'h00, 0);
      `CHK("primary", {24'h0, lf & 8'h7f}, q)
      bus(1, 8'h04, {24'h0, lf});
      bus(0, 8'h04, 0);
      `CHK("secondary", {24'h0, lf & 8'h77}, q)
      bus(1, 8'h14, {24'h0, lf});
      bus(0, 8'h14, 0);
      `CHK("unmapped", 32'h0, q)
    end
    $display("round trips done");
    bus(1, 8'h10, 32'h7);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 6; i++) begin
        bus(1, 8'h00, 0);
        bus(1, 8'h04, 32'h7);
        bus(1, 8'h08, s);
        bus(1, 8'h0c, 32'h7);
        fire(i);
        e = prim_exp(i, s);
        bus(0, 8'h00, 0);
        `CHK("primary flag", {24'h0, e}, q)
        bus(0, 8'h04, 0);
        `CHK("secondary flag", 32'h7 | (i < 3 ? 32'h10 << i : 32'h0), q)
        bus(0, 8'h0c, 0);
        `CHK("status", {29'h0, e[4], e[5], e[6]}, q)
        `CHK("irq", e != 0, irq)
      end
    end
    $display("sources done");
    // a gathered source whose own enable is low must not reach the combined flag
    bus(1, 8'h04, 32'h0);
    bus(1, 8'h00, 32'h0b);
    fire(2);
    bus(0, 8'h04, 0);
    `CHK("gated secondary", 32'h40, q)
    bus(0, 8'h00, 0);
    `CHK("gated combined", 32'h0b, q)
    bus(1, 8'h00, 32'h21);
    @(posedge hclk);
    `CHK("source disabled", 1'h0, req)
    bus(1, 8'h00, 32'h25);
    @(posedge hclk);
    `CHK("source enabled", 1'h1, req)
    bus(1, 8'h00, 32'h0);
    $display("gating done");
    for (int sl = 0; sl < 2; sl++) begin
      slow <= sl[0];
      take_en <= 1;
      bus(1, 8'h00, 32'h0e);
      fire(3);
      `CHK("masked request", 1'h0, req)
      bus(1, 8'h00, 32'h2f);
      n = 0;
      do begin @(posedge hclk); n++; end while (acc !== 1'h1 && n < 20);
      if (n >= 20) begin bad_count++; wrap_up; end
      `CHK("accept seen", 1'h1, acc)
      `CHK("request at accept", 1'h1, req)
      @(posedge hclk);
      `CHK("request dropped", 1'h0, req)
      bus(0, 8'h00, 0);
      `CHK("global cleared", 32'h2e, q)
    end
    $display("core handshake done");
    wrap_up;
  end
endmodule
`default_nettype wire

// >>> dv/primary_interrupt_control_monitor.sv
// port-level assertions for the primary interrupt control
`timescale 1ns/1ps
`default_nettype none
module irq_watch (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic ext_interrupt_pin,
  input wire logic low_voltage_detector_out,
  input wire logic comparator_one_event,
  input wire logic timer_one_event,
  input wire logic comparator_two_event,
  input wire logic comparator_three_event,
  input wire logic core_interrupt_accept,
  input wire logic core_interrupt_request,
  input wire logic irq
);
  logic cause;
  logic [3:0] hist;
  // anything that may legally move the request: bus access, source, accept
  assign cause = (hsel & htrans[1] & hready) | ext_interrupt_pin | low_voltage_detector_out
    | comparator_one_event | timer_one_event | comparator_two_event
    | comparator_three_event | core_interrupt_accept;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hist <= '0;
    else hist <= {hist[2:0], cause};
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_taken;
    core_interrupt_accept && core_interrupt_request;
  endsequence
  sequence s_dropped;
    !core_interrupt_request;
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_phase: assert property (hrdata != 0 |-> $past(hsel && htrans[1] && !hwrite && hready))
    else $error("hrdata outside read phase");
  a_taken_clears: assert property (s_taken |=> s_dropped)
    else $error("request survives accept");
  a_req_rise_cause: assert property ($rose(core_interrupt_request) |-> hist != 0)
    else $error("request rose without cause");
  a_irq_rise_cause: assert property ($rose(irq) |-> hist != 0)
    else $error("irq rose without cause");
  a_req_fall_cause: assert property ($fell(core_interrupt_request) |-> hist != 0)
    else $error("request fell without cause");
  a_req_hold: assert property (core_interrupt_request && !cause && hist == 0 |=> core_interrupt_request)
    else $error("request dropped alone");
endmodule
bind primary_interrupt_control irq_watch u_watch (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .ext_interrupt_pin, .low_voltage_detector_out,
  .comparator_one_event, .timer_one_event, .comparator_two_event, .comparator_three_event,
  .core_interrupt_accept, .core_interrupt_request, .irq);
`default_nettype wire

// >>> logic/primary_interrupt_control.sv
// primary interrupt control: flags, enables, global enable and core request over ahb-lite
`timescale 1ns/1ps
`default_nettype none
`include "primary_interrupt_control_defs.svh"
module primary_interrupt_control
  import primary_interrupt_control_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic hreadyout,
  output var logic [31:0] hrdata,
  output var logic hresp,
  input wire logic ext_interrupt_pin,
  input wire logic low_voltage_detector_out,
  input wire logic comparator_one_event,
  input wire logic timer_one_event,
  input wire logic comparator_two_event,
  input wire logic comparator_three_event,
  input wire logic core_interrupt_accept,
  output var logic core_interrupt_request,
  output var logic irq
);

  control_state_type s;
  control_state_type next_s;

  source_event_if events ();

  source_edge_capture capture (
    .hclk(hclk),
    .hresetn(hresetn),
    .ext_interrupt_pin(ext_interrupt_pin),
    .low_voltage_detector_out(low_voltage_detector_out),
    .comparator_one_event(comparator_one_event),
    .timer_one_event(timer_one_event),
    .comparator_two_event(comparator_two_event),
    .comparator_three_event(comparator_three_event),
    .events(events)
  );

  // address phase decode; only word transfers are expected, so hsize is not decoded
  logic access;
  logic read_access;
  logic write_access;
  logic [7:0] access_index;

  assign access = hsel & htrans[`HTRANS_ACTIVE_BIT] & hready;
  assign read_access = access & ~hwrite;
  assign write_access = access & hwrite;
  assign access_index = 8'(haddr[ADDR_WIDTH-1:0]);

  // data phase write strobes
  logic wr_primary;
  logic wr_secondary;
  logic wr_config;
  logic wr_status;
  logic wr_mask;

  assign wr_primary = s.write_pending & (s.write_index == `OFS_PRIMARY);
  assign wr_secondary = s.write_pending & (s.write_index == `OFS_SECONDARY);
  assign wr_config = s.write_pending & (s.write_index == `OFS_CONFIG);
  assign wr_status = s.write_pending & (s.write_index == `OFS_STATUS);
  assign wr_mask = s.write_pending & (s.write_index == `OFS_MASK);

  // read mux over the next state, so a read right behind a write sees the new value
  function automatic logic [31:0] read_value(
    input control_state_type v,
    input logic [7:0] index
  );
    logic [31:0] r;
    r = `READ_ZERO;
    unique case (index)
      `OFS_PRIMARY: r[7:0] = v.primary & `PRIMARY_WMASK;
      `OFS_SECONDARY: r[7:0] = v.secondary & `SECONDARY_WMASK;
      `OFS_CONFIG: r[`BIT_LOWVOLT_SELECT] = v.lowvolt_select;
      `OFS_STATUS: r[`STATUS_WIDTH-1:0] = v.status;
      `OFS_MASK: r[`STATUS_WIDTH-1:0] = v.mask;
      default: r = `READ_ZERO;
    endcase
    return r;
  endfunction

  // events that set flags this cycle
  logic pin_lv_set;
  logic cp1_set;
  logic [7:0] secondary_set;
  logic comb_set;

  always_comb begin
    // the option picks which of the two sources owns the shared flag
    pin_lv_set = s.lowvolt_select ? events.lowvolt_event : events.pin_event;
    cp1_set = events.cmp1_event;
    secondary_set = 8'h00;
    secondary_set[`BIT_T1_FLAG] = events.timer1_event;
    secondary_set[`BIT_CP2_FLAG] = events.cmp2_event;
    secondary_set[`BIT_CP3_FLAG] = events.cmp3_event;
    // a gathered source only reaches the combined flag through its own enable
    comb_set = (secondary_set[`BIT_T1_FLAG] & s.secondary[`BIT_T1_EN])
             | (secondary_set[`BIT_CP2_FLAG] & s.secondary[`BIT_CP2_EN])
             | (secondary_set[`BIT_CP3_FLAG] & s.secondary[`BIT_CP3_EN]);
  end

  // pending and enabled per source, before the global gate
  logic pin_lv_ready;
  logic cp1_ready;
  logic comb_ready;
  logic any_ready;

  always_comb begin
    next_s = s;

    // bus pipeline: every transfer is answered with zero wait states
    next_s.hreadyout = 1'b1;
    next_s.hresp = `HRESP_OKAY;
    next_s.write_pending = write_access;
    next_s.write_index = write_access ? access_index : s.write_index;

    // primary register: software write first, then hardware sets on top
    if (wr_primary) begin
      next_s.primary = hwdata[7:0] & `PRIMARY_WMASK;
    end
    // a taken interrupt drops the global enable; a write in the same cycle wins
    if (core_interrupt_accept && s.core_request && !wr_primary) begin
      next_s.primary[`BIT_GLOBAL_EN] = 1'b0;
    end
    // set beats a software clear landing in the same cycle
    if (pin_lv_set) begin
      next_s.primary[`BIT_PIN_LV_FLAG] = 1'b1;
    end
    if (cp1_set) begin
      next_s.primary[`BIT_CP1_FLAG] = 1'b1;
    end
    if (comb_set) begin
      next_s.primary[`BIT_COMB_FLAG] = 1'b1;
    end

    // secondary register holding the gathered sources
    if (wr_secondary) begin
      next_s.secondary = hwdata[7:0] & `SECONDARY_WMASK;
    end
    next_s.secondary = next_s.secondary | secondary_set;

    // source option; changing it does not move a flag already pending
    if (wr_config) begin
      next_s.lowvolt_select = hwdata[`BIT_LOWVOLT_SELECT];
    end

    // sticky event status, cleared by writing ones, a new event wins
    if (wr_status) begin
      next_s.status = s.status & ~hwdata[`STATUS_WIDTH-1:0];
    end
    next_s.status[`ST_PIN_LV] = next_s.status[`ST_PIN_LV] | pin_lv_set;
    next_s.status[`ST_CP1] = next_s.status[`ST_CP1] | cp1_set;
    next_s.status[`ST_COMB] = next_s.status[`ST_COMB] | comb_set;

    if (wr_mask) begin
      next_s.mask = hwdata[`STATUS_WIDTH-1:0];
    end

    // worked out here, once the flags have settled, so no loop runs through a second process
    pin_lv_ready = next_s.primary[`BIT_PIN_LV_FLAG] & next_s.primary[`BIT_PIN_LV_EN];
    cp1_ready = next_s.primary[`BIT_CP1_FLAG] & next_s.primary[`BIT_CP1_EN];
    comb_ready = next_s.primary[`BIT_COMB_FLAG] & next_s.primary[`BIT_COMB_EN];
    any_ready = pin_lv_ready | cp1_ready | comb_ready;

    // request to the core only with flag, enable and global enable all high
    next_s.core_request = next_s.primary[`BIT_GLOBAL_EN] & any_ready;

    // system interrupt line follows unmasked sticky status
    next_s.irq = |(next_s.status & next_s.mask);

    // read data is loaded at the address phase edge and stands for the data phase
    next_s.hrdata = read_access ? read_value(next_s, access_index) : `READ_ZERO;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s.primary <= `PRIMARY_RESET;
      s.secondary <= `SECONDARY_RESET;
      s.lowvolt_select <= 1'b0;
      s.status <= `STATUS_RESET;
      s.mask <= `MASK_RESET;
      s.write_pending <= 1'b0;
      s.write_index <= 8'h00;
      s.hrdata <= `READ_ZERO;
      s.hreadyout <= 1'b1;
      s.hresp <= `HRESP_OKAY;
      s.core_request <= 1'b0;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;
  assign core_interrupt_request = s.core_request;
  assign irq = s.irq;

endmodule
`default_nettype wire

// >>> logic/source_edge_capture.sv
// registers raw pin and peripheral signals as source events; only the pin and low-voltage level are cut to one-cycle rising edges
`timescale 1ns/1ps
`default_nettype none
module source_edge_capture
  import primary_interrupt_control_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ext_interrupt_pin,
  input wire logic low_voltage_detector_out,
  input wire logic comparator_one_event,
  input wire logic timer_one_event,
  input wire logic comparator_two_event,
  input wire logic comparator_three_event,
  source_event_if.producer events
);

  capture_state_type s;
  capture_state_type next_s;

  always_comb begin
    next_s = s;
    next_s.pin_prev = ext_interrupt_pin;
    next_s.lowvolt_prev = low_voltage_detector_out;
    // rising edges only: a held pin or a standing low-voltage level asks once
    next_s.pin_event = ext_interrupt_pin & ~s.pin_prev;
    next_s.lowvolt_event = low_voltage_detector_out & ~s.lowvolt_prev;
    next_s.cmp1_event = comparator_one_event;
    next_s.timer1_event = timer_one_event;
    next_s.cmp2_event = comparator_two_event;
    next_s.cmp3_event = comparator_three_event;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign events.pin_event = s.pin_event;
  assign events.lowvolt_event = s.lowvolt_event;
  assign events.cmp1_event = s.cmp1_event;
  assign events.timer1_event = s.timer1_event;
  assign events.cmp2_event = s.cmp2_event;
  assign events.cmp3_event = s.cmp3_event;

endmodule
`default_nettype wire

// >>> pkg/primary_interrupt_control_defs.svh
// offsets, bit positions, reset values and bus codes of the primary interrupt control
`ifndef PRIMARY_INTERRUPT_CONTROL_DEFS_SVH
`define PRIMARY_INTERRUPT_CONTROL_DEFS_SVH

`define OFS_PRIMARY 8'h00
`define OFS_SECONDARY 8'h04
`define OFS_CONFIG 8'h08
`define OFS_STATUS 8'h0c
`define OFS_MASK 8'h10

`define BIT_PIN_LV_FLAG 6
`define BIT_CP1_FLAG 5
`define BIT_COMB_FLAG 4
`define BIT_PIN_LV_EN 3
`define BIT_CP1_EN 2
`define BIT_COMB_EN 1
`define BIT_GLOBAL_EN 0

`define BIT_T1_FLAG 6
`define BIT_CP2_FLAG 5
`define BIT_CP3_FLAG 4
`define BIT_T1_EN 2
`define BIT_CP2_EN 1
`define BIT_CP3_EN 0

`define BIT_LOWVOLT_SELECT 0

`define ST_PIN_LV 0
`define ST_CP1 1
`define ST_COMB 2
`define STATUS_WIDTH 3

`define PRIMARY_WMASK 8'h7f
`define SECONDARY_WMASK 8'h77
`define PRIMARY_RESET 8'h00
`define SECONDARY_RESET 8'h00
`define STATUS_RESET 3'h0
`define MASK_RESET 3'h0

`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'b0
`define READ_ZERO 32'h0000_0000

`endif

// >>> pkg/primary_interrupt_control_pkg.sv
// state types of the primary interrupt control and its source capture
`include "primary_interrupt_control_defs.svh"
package primary_interrupt_control_pkg;

  typedef struct packed {
    logic [7:0] primary;
    logic [7:0] secondary;
    logic lowvolt_select;
    logic [`STATUS_WIDTH-1:0] status;
    logic [`STATUS_WIDTH-1:0] mask;
    logic write_pending;
    logic [7:0] write_index;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic core_request;
    logic irq;
  } control_state_type;

  typedef struct packed {
    logic pin_prev;
    logic lowvolt_prev;
    logic pin_event;
    logic lowvolt_event;
    logic cmp1_event;
    logic timer1_event;
    logic cmp2_event;
    logic cmp3_event;
  } capture_state_type;

endpackage

// >>> pkg/source_event_if.sv
// source events passed from the capture stage to the control registers; only the pin and low-voltage events are one-cycle edges
`timescale 1ns/1ps
`default_nettype none
interface source_event_if;
  logic pin_event;
  logic lowvolt_event;
  logic cmp1_event;
  logic timer1_event;
  logic cmp2_event;
  logic cmp3_event;

  modport producer (
    output pin_event,
    output lowvolt_event,
    output cmp1_event,
    output timer1_event,
    output cmp2_event,
    output cmp3_event
  );

  modport consumer (
    input pin_event,
    input lowvolt_event,
    input cmp1_event,
    input timer1_event,
    input cmp2_event,
    input cmp3_event
  );
endinterface
`default_nettype wire
